// >>> core/mcb_branch_unit.sv
// microcore fetch/branch core: fetches words from code memory and
// executes the four conditional branches; other words step the pc.
// assumes a code memory with one cycle read latency and an apb master.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps

module mcb_branch_unit #(
  parameter int CODE_AW = mcb_pkg::MCB_CODE_AW,
  parameter bit CORE_CHANNEL = 1'b0,
  parameter bit CORE_WORD = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [CODE_AW-1:0] code_addr,
  output logic code_rd,
  input wire logic [15:0] code_word,
  input wire logic [15:0] alu_condition_flags,
  input wire logic [15:0] feedback_flags,
  output logic [15:0] exec_word,
  output logic exec_valid,
  output logic branch_taken
);
  import mcb_pkg::*;

  // ===========================================================
  // register file state
  logic [15:0] microcore_control_word [4];
  logic [15:0] next_control_word [4];
  logic [CODE_AW-1:0] jump_target_register_set [2];
  logic [CODE_AW-1:0] next_jump [2];
  logic run;
  logic next_run;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // ===========================================================
  // core state
  mcb_state_t state;
  mcb_state_t next_state;
  logic [CODE_AW-1:0] microcore_program_counter;
  logic [CODE_AW-1:0] next_pc;
  logic [15:0] next_exec_word;
  logic next_exec_valid;
  logic next_branch_taken;
  logic last_taken;
  logic next_last_taken;

  // ===========================================================
  // apb decode
  logic setup_phase;
  logic access_wr;
  logic [MCB_IDX_W-1:0] reg_idx;
  logic reg_hit;
  logic [31:0] reg_rdata;
  logic pc_wr;
  logic [15:0] own_control_word;
  logic [3:0] ctrl_wr;
  localparam logic [MCB_IDX_W-1:0] CTRL_IDX [4] = '{
    MCB_IDX_CTRL_A_CH1, MCB_IDX_CTRL_B_CH1,
    MCB_IDX_CTRL_A_CH2, MCB_IDX_CTRL_B_CH2
  };

  assign setup_phase = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  assign reg_idx = paddr[MCB_IDX_W+1:2];
  // zero wait state: read data is staged in the setup cycle
  assign pready = 1'b1;
  // pc loads only while stopped, so a running loop is never torn
  assign pc_wr = access_wr & (reg_idx == MCB_IDX_PC) & ~run;
  assign own_control_word = microcore_control_word[{CORE_CHANNEL, CORE_WORD}];

  // one write strobe per control word, entry k is {channel, word}
  for (genvar k = 0; k < 4; k++) begin : g_ctrl_wr
    assign ctrl_wr[k] = access_wr & (reg_idx == CTRL_IDX[k]);
  end

  always_comb begin
    reg_hit = 1'b1;
    reg_rdata = 32'h0000_0000;
    case (reg_idx)
      MCB_IDX_CTRL_A_CH1: reg_rdata[15:0] = microcore_control_word[0];
      MCB_IDX_CTRL_B_CH1: reg_rdata[15:0] = microcore_control_word[1];
      MCB_IDX_CTRL_A_CH2: reg_rdata[15:0] = microcore_control_word[2];
      MCB_IDX_CTRL_B_CH2: reg_rdata[15:0] = microcore_control_word[3];
      MCB_IDX_JUMP0: reg_rdata[CODE_AW-1:0] = jump_target_register_set[0];
      MCB_IDX_JUMP1: reg_rdata[CODE_AW-1:0] = jump_target_register_set[1];
      MCB_IDX_PC: begin
        reg_rdata[CODE_AW-1:0] = microcore_program_counter;
        reg_rdata[MCB_TAKEN_BIT] = last_taken;
        reg_rdata[MCB_RUNNING_BIT] = (state != MCB_ST_IDLE);
      end
      MCB_IDX_RUN: reg_rdata[MCB_RUN_BIT] = run;
      default: reg_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_control_word = microcore_control_word;
    next_jump = jump_target_register_set;
    next_run = run;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup_phase) begin
      next_prdata = pwrite ? 32'h0000_0000 : reg_rdata;
      next_pslverr = ~reg_hit;
    end
    for (int k = 0; k < 4; k++) begin
      if (ctrl_wr[k]) begin
        next_control_word[k] = pwdata[15:0];
      end
    end
    if (access_wr) begin
      case (reg_idx)
        MCB_IDX_JUMP0: next_jump[0] = pwdata[CODE_AW-1:0];
        MCB_IDX_JUMP1: next_jump[1] = pwdata[CODE_AW-1:0];
        MCB_IDX_RUN: next_run = pwdata[MCB_RUN_BIT];
        default: next_run = run;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        microcore_control_word[i] <= MCB_CTRL_RST;
      end
      for (int j = 0; j < 2; j++) begin
        jump_target_register_set[j] <= CODE_AW'(MCB_JUMP_RST);
      end
      run <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      microcore_control_word <= next_control_word;
      jump_target_register_set <= next_jump;
      run <= next_run;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ===========================================================
  // instruction decode
  logic is_arith_rel;
  logic is_ctrl_abs;
  logic is_ctrl_rel;
  logic is_fbk_abs;
  logic [3:0] alu_condition_choice;
  logic [3:0] control_bit_choice;
  logic [3:0] feedback_choice;
  logic jump_register_choice;
  logic ctrl_pol;
  logic fbk_pol;
  logic alu_hit;
  logic ctrl_hit;
  logic fbk_hit;
  logic [CODE_AW-1:0] rel_target;
  logic [CODE_AW-1:0] abs_target;
  logic [CODE_AW-1:0] seq_target;

  assign is_arith_rel = (code_word[15:9] == MCB_OP_ARITH_REL);
  assign is_ctrl_abs = (code_word[15:10] == MCB_OP_CTRL_ABS)
                       && (code_word[3:0] == MCB_ABS_TAIL);
  assign is_ctrl_rel = (code_word[15:10] == MCB_OP_CTRL_REL);
  assign is_fbk_abs = (code_word[15:10] == MCB_OP_FBK_ABS)
                      && (code_word[3:0] == MCB_ABS_TAIL);

  assign alu_condition_choice = code_word[MCB_SEL_LSB +: 4];
  assign control_bit_choice = code_word[MCB_SEL_LSB +: 4];
  assign ctrl_pol = code_word[MCB_POL_BIT];
  assign feedback_choice = code_word[MCB_FBK_SEL_LSB +: 4];
  assign fbk_pol = code_word[MCB_FBK_POL_BIT];
  assign jump_register_choice = code_word[MCB_JR_BIT];

  // ===========================================================
  // condition selection
  logic alu_bit;
  logic fbk_bit;
  logic ctrl_bit;
  logic [15:0] ctrl_pick;
  logic [CODE_AW-1:0] rel_offset;

  // codes name the flag vector bits one to one; default only for unknowns
  always_comb begin
    alu_bit = 1'b0;
    case (mcb_alu_cond_t'(alu_condition_choice))
      MCB_ALU_DONE: alu_bit = alu_condition_flags[MCB_ALU_DONE];
      MCB_ALU_OVF_S: alu_bit = alu_condition_flags[MCB_ALU_OVF_S];
      MCB_ALU_UNF_S: alu_bit = alu_condition_flags[MCB_ALU_UNF_S];
      MCB_ALU_OVF_U: alu_bit = alu_condition_flags[MCB_ALU_OVF_U];
      MCB_ALU_UNF_U: alu_bit = alu_condition_flags[MCB_ALU_UNF_U];
      MCB_ALU_SIGN: alu_bit = alu_condition_flags[MCB_ALU_SIGN];
      MCB_ALU_ZERO: alu_bit = alu_condition_flags[MCB_ALU_ZERO];
      MCB_ALU_MLOSS: alu_bit = alu_condition_flags[MCB_ALU_MLOSS];
      MCB_ALU_MOVER: alu_bit = alu_condition_flags[MCB_ALU_MOVER];
      MCB_ALU_MASK_ONES: alu_bit = alu_condition_flags[MCB_ALU_MASK_ONES];
      MCB_ALU_MASK_ZEROS: alu_bit = alu_condition_flags[MCB_ALU_MASK_ZEROS];
      MCB_ALU_ARITH_LO: alu_bit = alu_condition_flags[MCB_ALU_ARITH_LO];
      MCB_ALU_ARITH_HI: alu_bit = alu_condition_flags[MCB_ALU_ARITH_HI];
      MCB_ALU_CARRY: alu_bit = alu_condition_flags[MCB_ALU_CARRY];
      MCB_ALU_CONV_SIGN: alu_bit = alu_condition_flags[MCB_ALU_CONV_SIGN];
      MCB_ALU_SHIFT_CARRY: alu_bit = alu_condition_flags[MCB_ALU_SHIFT_CARRY];
      default: alu_bit = 1'b0;
    endcase
  end

  // high side pairs first, then the six low side drain-source inputs
  always_comb begin
    fbk_bit = 1'b0;
    case (mcb_fbk_sel_t'(feedback_choice))
      MCB_FB_HS1_DS: fbk_bit = feedback_flags[MCB_FB_HS1_DS];
      MCB_FB_HS1_SRC: fbk_bit = feedback_flags[MCB_FB_HS1_SRC];
      MCB_FB_HS2_DS: fbk_bit = feedback_flags[MCB_FB_HS2_DS];
      MCB_FB_HS2_SRC: fbk_bit = feedback_flags[MCB_FB_HS2_SRC];
      MCB_FB_HS3_DS: fbk_bit = feedback_flags[MCB_FB_HS3_DS];
      MCB_FB_HS3_SRC: fbk_bit = feedback_flags[MCB_FB_HS3_SRC];
      MCB_FB_HS4_DS: fbk_bit = feedback_flags[MCB_FB_HS4_DS];
      MCB_FB_HS4_SRC: fbk_bit = feedback_flags[MCB_FB_HS4_SRC];
      MCB_FB_HS5_DS: fbk_bit = feedback_flags[MCB_FB_HS5_DS];
      MCB_FB_HS5_SRC: fbk_bit = feedback_flags[MCB_FB_HS5_SRC];
      MCB_FB_LS1_DS: fbk_bit = feedback_flags[MCB_FB_LS1_DS];
      MCB_FB_LS2_DS: fbk_bit = feedback_flags[MCB_FB_LS2_DS];
      MCB_FB_LS3_DS: fbk_bit = feedback_flags[MCB_FB_LS3_DS];
      MCB_FB_LS4_DS: fbk_bit = feedback_flags[MCB_FB_LS4_DS];
      MCB_FB_LS5_DS: fbk_bit = feedback_flags[MCB_FB_LS5_DS];
      MCB_FB_LS6_DS: fbk_bit = feedback_flags[MCB_FB_LS6_DS];
      default: fbk_bit = 1'b0;
    endcase
  end

  // one and-or slice per control bit, code n picks bit n
  for (genvar b = 0; b < 16; b++) begin : g_ctrl_pick
    assign ctrl_pick[b] = own_control_word[b]
                          & (control_bit_choice == 4'(b));
  end
  assign ctrl_bit = |ctrl_pick;

  // polarity 1 takes a set bit, polarity 0 a clear bit
  assign alu_hit = alu_bit;
  assign ctrl_hit = (ctrl_bit == ctrl_pol);
  assign fbk_hit = (fbk_bit == fbk_pol);

  // offset is sign extended, so the sum wraps within the code space
  assign rel_offset = CODE_AW'($signed(code_word[MCB_OFS_LSB +: MCB_OFS_W]));
  assign rel_target = microcore_program_counter + rel_offset;
  assign abs_target = jump_target_register_set[jump_register_choice];
  assign seq_target = microcore_program_counter + CODE_AW'(1);

  // ===========================================================
  // fetch and execute sequence
  assign code_addr = microcore_program_counter;
  assign code_rd = (state == MCB_ST_FETCH);

  always_comb begin
    next_state = state;
    next_pc = microcore_program_counter;
    next_exec_word = exec_word;
    next_exec_valid = 1'b0;
    next_branch_taken = 1'b0;
    next_last_taken = last_taken;
    case (state)
      MCB_ST_IDLE: begin
        if (pc_wr) begin
          next_pc = pwdata[CODE_AW-1:0];
        end
        if (run) begin
          next_state = MCB_ST_FETCH;
        end
      end
      MCB_ST_FETCH: begin
        next_state = MCB_ST_EXEC;
      end
      MCB_ST_EXEC: begin
        next_exec_word = code_word;
        next_exec_valid = 1'b1;
        next_pc = seq_target;
        next_last_taken = 1'b0;
        // first match wins; the four opcodes never overlap anyway
        if (is_arith_rel && alu_hit) begin
          next_pc = rel_target;
          next_last_taken = 1'b1;
        end else if (is_ctrl_rel && ctrl_hit) begin
          next_pc = rel_target;
          next_last_taken = 1'b1;
        end else if (is_ctrl_abs && ctrl_hit) begin
          next_pc = abs_target;
          next_last_taken = 1'b1;
        end else if (is_fbk_abs && fbk_hit) begin
          next_pc = abs_target;
          next_last_taken = 1'b1;
        end
        next_branch_taken = next_last_taken;
        next_state = run ? MCB_ST_FETCH : MCB_ST_IDLE;
      end
      default: begin
        next_state = MCB_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MCB_ST_IDLE;
      microcore_program_counter <= CODE_AW'(MCB_PC_RST);
      exec_word <= 16'h0000;
      exec_valid <= 1'b0;
      branch_taken <= 1'b0;
      last_taken <= 1'b0;
    end else begin
      state <= next_state;
      microcore_program_counter <= next_pc;
      exec_word <= next_exec_word;
      exec_valid <= next_exec_valid;
      branch_taken <= next_branch_taken;
      last_taken <= next_last_taken;
    end
  end

endmodule

// >>> core/mcb_pkg.sv
// constants for the microcore conditional branch unit.
// assumes one microcore; registers on a 32-bit apb slave.
package mcb_pkg;

  // ===========================================================
  // code memory and word layout
  localparam int MCB_CODE_AW = 10;
  localparam int MCB_WORD_W = 16;
  localparam int MCB_OFS_W = 5;

  localparam logic [6:0] MCB_OP_ARITH_REL = 7'h12;
  localparam logic [5:0] MCB_OP_CTRL_ABS = 6'h0F;
  localparam logic [5:0] MCB_OP_CTRL_REL = 6'h08;
  localparam logic [5:0] MCB_OP_FBK_ABS = 6'h0E;
  localparam logic [3:0] MCB_ABS_TAIL = 4'h4;

  // field positions
  localparam int MCB_OFS_LSB = 0;
  localparam int MCB_SEL_LSB = 5;
  localparam int MCB_FBK_SEL_LSB = 6;
  localparam int MCB_POL_BIT = 9;
  localparam int MCB_FBK_POL_BIT = 5;
  localparam int MCB_JR_BIT = 4;

  // ===========================================================
  // condition selector codes, flag vector bit = code
  typedef enum logic [3:0] {
    MCB_ALU_DONE = 4'h0, MCB_ALU_OVF_S = 4'h1, MCB_ALU_UNF_S = 4'h2,
    MCB_ALU_OVF_U = 4'h3, MCB_ALU_UNF_U = 4'h4, MCB_ALU_SIGN = 4'h5,
    MCB_ALU_ZERO = 4'h6, MCB_ALU_MLOSS = 4'h7, MCB_ALU_MOVER = 4'h8,
    MCB_ALU_MASK_ONES = 4'h9, MCB_ALU_MASK_ZEROS = 4'hA,
    MCB_ALU_ARITH_LO = 4'hB, MCB_ALU_ARITH_HI = 4'hC,
    MCB_ALU_CARRY = 4'hD, MCB_ALU_CONV_SIGN = 4'hE,
    MCB_ALU_SHIFT_CARRY = 4'hF
  } mcb_alu_cond_t;

  typedef enum logic [3:0] {
    MCB_FB_HS1_DS = 4'h0, MCB_FB_HS1_SRC = 4'h1, MCB_FB_HS2_DS = 4'h2,
    MCB_FB_HS2_SRC = 4'h3, MCB_FB_HS3_DS = 4'h4, MCB_FB_HS3_SRC = 4'h5,
    MCB_FB_HS4_DS = 4'h6, MCB_FB_HS4_SRC = 4'h7, MCB_FB_HS5_DS = 4'h8,
    MCB_FB_HS5_SRC = 4'h9, MCB_FB_LS1_DS = 4'hA, MCB_FB_LS2_DS = 4'hB,
    MCB_FB_LS3_DS = 4'hC, MCB_FB_LS4_DS = 4'hD, MCB_FB_LS5_DS = 4'hE,
    MCB_FB_LS6_DS = 4'hF
  } mcb_fbk_sel_t;

  typedef enum logic [1:0] {
    MCB_ST_IDLE = 2'b00,
    MCB_ST_FETCH = 2'b01,
    MCB_ST_EXEC = 2'b11
  } mcb_state_t;

  // ===========================================================
  // register indices, byte address = index * 4
  localparam int MCB_IDX_W = 10;
  localparam logic [9:0] MCB_IDX_CTRL_A_CH1 = 10'h101;
  localparam logic [9:0] MCB_IDX_CTRL_B_CH1 = 10'h102;
  localparam logic [9:0] MCB_IDX_CTRL_A_CH2 = 10'h121;
  localparam logic [9:0] MCB_IDX_CTRL_B_CH2 = 10'h122;
  localparam logic [9:0] MCB_IDX_JUMP0 = 10'h140;
  localparam logic [9:0] MCB_IDX_JUMP1 = 10'h141;
  localparam logic [9:0] MCB_IDX_PC = 10'h142;
  localparam logic [9:0] MCB_IDX_RUN = 10'h143;

  localparam logic [15:0] MCB_CTRL_RST = 16'h0000;
  localparam logic [9:0] MCB_JUMP_RST = 10'h000;
  localparam logic [9:0] MCB_PC_RST = 10'h000;
  localparam int MCB_RUN_BIT = 0;
  localparam int MCB_TAKEN_BIT = 16;
  localparam int MCB_RUNNING_BIT = 17;

endpackage

// >>> dv/mcb_branch_unit_sva.sv
// checker for the branch unit, watching top ports only.
// assumes a bind from the bench top file.
`timescale 1ns/10ps
module mcb_branch_unit_sva
  import mcb_pkg::*;
#(parameter int CODE_AW = 10) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [CODE_AW-1:0] code_addr,
  input wire logic code_rd,
  input wire logic [15:0] code_word,
  input wire logic [15:0] alu_condition_flags,
  input wire logic [15:0] feedback_flags,
  input wire logic [15:0] exec_word,
  input wire logic exec_valid,
  input wire logic branch_taken
);
  // ===========================================================
  // flags as they stood during the execute cycle
  logic [15:0] alu_q;
  logic [15:0] fb_q;
  logic [15:0] w;
  logic [CODE_AW-1:0] ofs;
  logic ar, ca, cr, fa, bad;
  always_ff @(posedge pclk) begin
    alu_q <= alu_condition_flags;
    fb_q <= feedback_flags;
  end
  assign w = exec_word;
  assign ofs = {{(CODE_AW-5){w[4]}}, w[4:0]};
  assign ar = w[15:9] == MCB_OP_ARITH_REL;
  assign cr = w[15:10] == MCB_OP_CTRL_REL;
  assign ca = w[15:10] == MCB_OP_CTRL_ABS && w[3:0] == MCB_ABS_TAIL;
  assign fa = w[15:10] == MCB_OP_FBK_ABS && w[3:0] == MCB_ABS_TAIL;
  assign bad = (w[15:10] == MCB_OP_CTRL_ABS ||
    w[15:10] == MCB_OP_FBK_ABS) && w[3:0] != MCB_ABS_TAIL;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ===========================================================
  // assertions
  chk_exec_word: assert property (
    code_rd |-> ##2 (exec_valid && exec_word == $past(code_word)))
    else $error("executed word or pulse wrong");
  chk_taken_valid: assert property (branch_taken |-> exec_valid)
    else $error("taken without execute pulse");
  chk_arith_cond: assert property (
    exec_valid && ar |-> branch_taken == alu_q[w[8:5]])
    else $error("arithmetic condition decision wrong");
  chk_fbk_cond: assert property (
    exec_valid && fa |-> branch_taken == (fb_q[w[9:6]] == w[5]))
    else $error("feedback condition decision wrong");
  chk_rel_target: assert property (
    exec_valid && branch_taken && (ar || cr) && code_rd
    |-> code_addr == $past(code_addr, 2) + ofs)
    else $error("relative target wrong");
  chk_seq_step: assert property (
    exec_valid && !branch_taken && code_rd
    |-> code_addr == $past(code_addr, 2) + CODE_AW'(1))
    else $error("sequential step wrong");
  chk_other_word: assert property (
    exec_valid && !(ar || cr || ca || fa) |-> !branch_taken)
    else $error("branch taken on foreign word");
  chk_abs_tail: assert property (
    exec_valid && bad |-> !branch_taken)
    else $error("absolute branch with wrong tail taken");
endmodule

// >>> dv/mcb_code_mem.sv
// code memory model, one cycle read latency.
// assumes the bench fills mem directly before the core runs.
`timescale 1ns/10ps
module mcb_code_mem #(parameter int AW = 10) (
  input wire logic clk,
  input wire logic rd,
  input wire logic [AW-1:0] addr,
  output logic [15:0] word
);
  logic [15:0] mem [2**AW];
  initial word = 16'h0000;
  // outside a read the bus toggles, so a late sample cannot pass
  always @(posedge clk) begin
    if (rd) word <= mem[addr];
    else word <= ~word;
  end
endmodule

// >>> dv/microcore_conditional_branch_unit_tb.sv
// bench for the branch unit: apb set-up, free-running program check.
// assumes the core tests control word a of channel 1 (defaults).
`timescale 1ns/10ps
module microcore_conditional_branch_unit_tb;
  import mcb_pkg::*;
  localparam logic [15:0] CTRL = 16'h5A3C;
  localparam logic [9:0] JUMP0 = 10'h3A5;
  localparam logic [9:0] JUMP1 = 10'h0F0;
  logic pclk = 0, presetn = 0, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, code_rd, exec_valid, branch_taken;
  logic [9:0] code_addr;
  logic [15:0] code_word, alu_condition_flags, feedback_flags, exec_word;
  logic prev_rd = 0, pend = 0;
  logic [9:0] pc_f;
  logic [11:0] seen;
  logic [31:0] exp_pc;
  logic [10:0] exp_r;
  int err_count = 0, checks_done = 0;
  logic [9:0] starts [3] = '{10'h000, 10'h2B7, 10'h3FE};
  always #20 pclk = ~pclk;
  mcb_branch_unit i_mcb_branch_unit (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .code_addr(code_addr), .code_rd(code_rd), .code_word(code_word),
    .alu_condition_flags(alu_condition_flags),
    .feedback_flags(feedback_flags), .exec_word(exec_word),
    .exec_valid(exec_valid), .branch_taken(branch_taken));
  mcb_code_mem i_mcb_code_mem (.clk(pclk), .rd(code_rd), .addr(code_addr),
    .word(code_word));
  task automatic end_of_test;
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ===========================================================
  // apb transfer; reads compare data and error response
  task automatic apb(input logic [9:0] idx, input logic wr,
    input logic [31:0] wd, input logic [31:0] exp, input logic xerr);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("ERROR %0t apb wait ran out", $time);
      end_of_test;
    end
    if (!wr) check(prdata, exp);
    if (!wr) check(32'(pslverr), 32'(xerr));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // ===========================================================
  // reference for the next pc, {taken, pc}
  function automatic logic [10:0] next_pc(logic [9:0] pc, logic [15:0] w,
    logic [15:0] alu, logic [15:0] fb);
    logic t, ab;
    ab = w[3:0] == MCB_ABS_TAIL && (w[15:10] == MCB_OP_CTRL_ABS ||
      w[15:10] == MCB_OP_FBK_ABS);
    t = 1'b0;
    if (w[15:9] == MCB_OP_ARITH_REL) t = alu[w[8:5]];
    if (w[15:10] == MCB_OP_CTRL_REL || (ab && w[15:10] == MCB_OP_CTRL_ABS))
      t = CTRL[w[8:5]] == w[9];
    if (ab && w[15:10] == MCB_OP_FBK_ABS) t = fb[w[9:6]] == w[5];
    if (!t) return {t, pc + 10'h001};
    if (ab) return {t, w[4] ? JUMP1 : JUMP0};
    return {t, pc + {{5{w[4]}}, w[4:0]}};
  endfunction
  function automatic logic [15:0] prog(logic [9:0] a);
    case (a % 5)
      0: return {MCB_OP_ARITH_REL, a[3:0] ^ a[7:4], a[4:0] + a[9:5]};
      1: return {MCB_OP_CTRL_ABS, a[5], a[9:6], a[0], MCB_ABS_TAIL};
      2: return {MCB_OP_CTRL_REL, a[6], a[3:0] + a[7:4], a[8:4]};
      3: return {MCB_OP_FBK_ABS, a[4:1] ^ a[9:6], a[7], a[2], MCB_ABS_TAIL};
      default: return {a[1] ? MCB_OP_CTRL_ABS : MCB_OP_FBK_ABS, a[5:0], 4'h5};
    endcase
  endfunction
  // flags move every cycle so each decision sees fresh values
  always @(posedge pclk) begin
    alu_condition_flags <= {alu_condition_flags[14:0],
      alu_condition_flags[15] ^ alu_condition_flags[10]};
    feedback_flags <= {feedback_flags[0] ^ feedback_flags[5],
      feedback_flags[15:1]};
  end
  always @(posedge pclk) begin
    seen = {exec_valid, branch_taken, code_addr};
    if (pend) check(32'(seen), 32'({1'b1, exp_r}));
    pend = prev_rd & presetn;
    // model pc follows its own decisions and pc writes while stopped
    if (prev_rd) begin
      exp_r = next_pc(pc_f, prog(pc_f), alu_condition_flags, feedback_flags);
      pc_f = exp_r[9:0];
    end
    if (psel && penable && pwrite && paddr[11:2] == MCB_IDX_PC)
      pc_f = pwdata[9:0];
    prev_rd = code_rd;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    alu_condition_flags = 16'hACE1;
    feedback_flags = 16'h3C5A;
    for (int i = 0; i < 1024; i++) i_mcb_code_mem.mem[i] = prog(10'(i));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(MCB_IDX_CTRL_A_CH1, 0, 0, 32'(MCB_CTRL_RST), 0);
    apb(MCB_IDX_CTRL_A_CH1, 1, 32'(CTRL), 0, 0);
    apb(MCB_IDX_CTRL_B_CH1, 1, 32'(~CTRL), 0, 0);
    apb(MCB_IDX_JUMP0, 1, 32'(JUMP0), 0, 0);
    apb(MCB_IDX_JUMP1, 1, 32'(JUMP1), 0, 0);
    apb(MCB_IDX_CTRL_A_CH1, 0, 0, 32'(CTRL), 0);
    apb(MCB_IDX_CTRL_B_CH1, 0, 0, {16'h0000, ~CTRL}, 0);
    apb(MCB_IDX_CTRL_B_CH2, 0, 0, 32'(MCB_CTRL_RST), 0);
    apb(MCB_IDX_CTRL_A_CH2, 1, 32'h0000_C3A5, 0, 0);
    apb(MCB_IDX_CTRL_A_CH2, 0, 0, 32'h0000_C3A5, 0);
    apb(MCB_IDX_JUMP0, 0, 0, 32'(JUMP0), 0);
    apb(MCB_IDX_JUMP1, 0, 0, 32'(JUMP1), 0);
    apb(MCB_IDX_RUN, 0, 0, 32'h0000_0000, 0);
    apb(10'h100, 0, 0, 32'h0000_0000, 1);
    foreach (starts[s]) begin
      apb(MCB_IDX_PC, 1, 32'(starts[s]), 0, 0);
      apb(MCB_IDX_RUN, 1, 32'h0000_0001, 0, 0);
      repeat (300) @(posedge pclk);
      apb(MCB_IDX_RUN, 1, 32'h0000_0000, 0, 0);
      repeat (8) @(posedge pclk);
      exp_pc = {15'h0, exp_r[10], 6'h0, exp_r[9:0]};
      apb(MCB_IDX_PC, 0, 0, exp_pc, 0);
    end
    end_of_test;
  end
endmodule
bind mcb_branch_unit mcb_branch_unit_sva #(.CODE_AW(CODE_AW))
  i_mcb_branch_unit_sva (.pclk(pclk), .presetn(presetn),
  .code_addr(code_addr), .code_rd(code_rd), .code_word(code_word),
  .alu_condition_flags(alu_condition_flags),
  .feedback_flags(feedback_flags), .exec_word(exec_word),
  .exec_valid(exec_valid), .branch_taken(branch_taken));
